//--- shared/cas_defs.svh
// named constants for the signaling and bandwidth-release block
`ifndef CAS_DEFS_SVH
`define CAS_DEFS_SVH
`define CAS_T1_SLOTS 5'h18
`define CAS_E1_SLOTS 5'h1F
`define CAS_MAX_SLOTS 31
`define CAS_MF_LAST 2'h3
`define CAS_MF_FIRST 2'h0
`define CAS_SIG_BIT 0
`define CAS_USER_KBPS 56
`define CAS_SIG_KBPS 8
`define CAS_ONE_SLOT 5'h01
`define CAS_ZERO_SLOT 5'h00
`define CAS_CNT_ZERO 16'h0000
`define CAS_CNT_STEP 16'h0001
`endif

//--- shared/cas_pkg.sv
// types shared by the signaling and bandwidth-release block
package cas_pkg;
  typedef enum logic {
    OFF_HOOK = 1'b0,
    ON_HOOK = 1'b1
  } hook_e;

  typedef struct packed {
    logic structured;
    logic cas_en;
    logic hook_en;
    logic e1;
    logic [4:0] ing_base;
    logic [4:0] eg_base;
    logic [4:0] count;
    logic [3:0] onhook_pat;
    logic [15:0] dummy_int;
  } cfg_s;

  typedef struct packed {
    logic valid;
    logic [4:0] slot;
    logic [7:0] data;
  } line_s;

  typedef struct packed {
    logic valid;
    logic dummy;
    logic cas;
    logic [4:0] offset;
    logic [7:0] payload;
    logic [3:0] abcd;
  } cell_s;
endpackage

//--- test/cas_signaling_bandwidth_release_test.sv
// self-checking bench for the signaling and bandwidth-release block
`timescale 1ns/1ns
`default_nettype none
module cas_signaling_bandwidth_release_test
  import cas_pkg::*;
;
  logic clk;
  logic reset_n;
  logic go;
  logic frame_start;
  logic on_hook;
  logic reserved;
  logic [4:0] slot;
  logic [7:0] data;
  logic [7:0] p;
  logic [3:0] abcd;
  logic [3:0] pat;
  cfg_s cfg;
  cfg_s c;
  line_s line_in;
  line_s line_out;
  line_s lgot;
  cell_s cell_in;
  cell_s cell_out;
  cell_s got;
  cell_s dgot;
  int fail_count = 0;
  int checks = 0;
  int dummies = 0;
  int frames = 0;

  pbx_line_model i_pbx_line_model(.clk(clk), .reset_n(reset_n), .go(go), .slot(slot),
    .data(data), .abcd(abcd), .line_in(line_in), .frame_start(frame_start));
  cas_signaling_bandwidth_release i_cas_signaling_bandwidth_release(.clk(clk),
    .reset_n(reset_n), .cfg(cfg), .frame_start(frame_start), .line_in(line_in),
    .cell_in(cell_in), .cell_out(cell_out), .line_out(line_out), .on_hook(on_hook),
    .reserved(reserved));

  // ---
  // clock, monitor, watchdog
  // ---
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cell_out.valid === 1'b1 && cell_out.dummy === 1'b1) begin
      dummies++;
      dgot = cell_out;
    end
  end
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [19:0] g, input logic [19:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  // bit 0 of a plain byte is the line's signaling bit of the frame just sent
  function automatic cell_s exp_cell(input logic [4:0] off, input logic s, input logic [3:0] n);
    logic [1:0] ph;
    ph = 2'(frames - 1);
    exp_cell = {1'b1, 1'b0, s, off, data[7:1], s ? 1'b0 : abcd[~ph], s ? n : 4'h0};
  endfunction
  // phase of the multiframe decides which signaling bit lands in bit 0
  function automatic line_s exp_line(input logic [4:0] off, input logic [7:0] d,
    input logic [3:0] n);
    exp_line = {1'b1, 5'(cfg.eg_base + off), d[7:1], n[~frames[1:0]]};
  endfunction
  task automatic do_reset(input cfg_s k, input logic r);
    @(posedge clk);
    reset_n <= 1'b0;
    cfg <= k;
    repeat (3) @(posedge clk);
    #1 check(cell_out, 20'h0);
    check(20'({line_out, on_hook, reserved}), 20'h0);
    @(posedge clk);
    reset_n <= 1'b1;
    frames = 0;
    @(posedge clk);
    #1 check(20'(reserved), 20'(r));
  endtask
  task automatic send_frame(input logic [4:0] s, input logic [3:0] n);
    @(posedge clk);
    go <= 1'b1;
    slot <= s;
    data <= 8'($urandom);
    abcd <= n;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1 got = cell_out;
    @(posedge clk);
    frames++;
  endtask
  task automatic send_cell(input logic [4:0] off, input logic dmy, input logic [7:0] d,
    input logic [3:0] n);
    @(posedge clk);
    cell_in <= {1'b1, dmy, 1'b1, off, d, n};
    @(posedge clk);
    cell_in.valid <= 1'b0;
    #1 lgot = line_out;
  endtask

  // ---
  // scenarios
  // ---
  initial begin
    reset_n = 1'b0;
    go = 1'b0;
    slot = 5'h00;
    data = 8'h00;
    abcd = 4'h0;
    cfg = '0;
    cell_in = '0;
    void'($urandom(16));
    c = '0;
    c.structured = 1'b1;
    c.count = 5'h03;
    c.ing_base = 5'($urandom_range(0, 20));
    c.eg_base = 5'($urandom_range(0, 20));
    do_reset(c, 1'b1);
    for (int i = 0; i < 3; i++) begin
      send_frame(5'(c.ing_base + i), 4'($urandom));
      check(got, exp_cell(5'(i), 1'b0, 4'h0));
    end
    c.structured = 1'b0;
    c.cas_en = 1'b1;
    do_reset(c, 1'b1);
    send_frame(5'h17, 4'hF);
    check(got, exp_cell(5'h17, 1'b0, 4'h0));
    p = 8'($urandom);
    send_cell(5'h10, 1'b0, p, 4'hF);
    check(20'(lgot), 20'({1'b1, 5'h10, p}));
    c.structured = 1'b1;
    do_reset(c, 1'b1);
    pat = 4'($urandom);
    for (int i = 0; i < 8; i++) begin
      send_frame(5'(c.ing_base + 1), pat);
      check(got, exp_cell(5'h01, 1'b1, i > 3 ? pat : 4'h0));
    end
    send_frame(5'(c.ing_base + 3), pat);
    check(20'(got.valid), 20'h0);
    for (int i = 0; i < 4; i++) begin
      p = 8'($urandom);
      send_cell(5'(i % 3), 1'b0, p, pat);
      check(20'(lgot), 20'(exp_line(5'(i % 3), p, pat)));
      send_cell(5'h00, 1'b1, p, pat);
      check(20'(lgot.valid), 20'h0);
      send_cell(5'h03, 1'b0, p, pat);
      check(20'(lgot.valid), 20'h0);
      send_frame(5'(c.ing_base + 4), pat);
    end
    c.hook_en = 1'b1;
    c.count = 5'h01;
    c.onhook_pat = pat;
    c.dummy_int = 16'h0001;
    do_reset(c, 1'b1);
    repeat (4) send_frame(c.ing_base, pat);
    #1 check(20'(on_hook), 20'h1);
    dummies = 0;
    repeat (8) begin
      send_frame(c.ing_base, pat);
      check(20'(got.valid), 20'h0);
    end
    repeat (2) @(posedge clk);
    #1 check(20'(dummies), 20'h4);
    check(dgot, {1'b1, 1'b1, 1'b1, 5'h00, 8'h00, pat});
    check(20'({on_hook, reserved}), 20'h3);
    repeat (4) send_frame(c.ing_base, ~pat);
    #1 check(20'(on_hook), 20'h0);
    send_frame(c.ing_base, ~pat);
    check(got, exp_cell(5'h00, 1'b1, ~pat));
    send_cell(5'h00, 1'b0, p, pat);
    check(20'(lgot), 20'(exp_line(5'h00, p, pat)));
    for (int k = 0; k < 2; k++) begin
      c.count = 5'(2 - k);
      c.cas_en = 1'(1 - k);
      do_reset(c, 1'b1);
      repeat (4) send_frame(c.ing_base, pat);
      #1 check(20'({got.valid, on_hook}), 20'h2);
    end
    c = '0;
    c.structured = 1'b1;
    c.e1 = 1'b1;
    c.ing_base = 5'h1C;
    c.eg_base = 5'h1C;
    c.count = 5'h03;
    do_reset(c, 1'b1);
    send_frame(5'h1E, pat);
    check(got, exp_cell(5'h02, 1'b0, 4'h0));
    c.e1 = 1'b0;
    do_reset(c, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- test/pbx_line_model.sv
// line-side partner: one slot byte then one frame marker per frame
`timescale 1ns/1ns
`default_nettype none
module pbx_line_model
  import cas_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic go,
  input wire logic [4:0] slot,
  input wire logic [7:0] data,
  input wire logic [3:0] abcd,
  output var line_s line_in,
  output var logic frame_start
);
  logic [1:0] ph;
  logic pend;
  initial begin
    line_in = '0;
    frame_start = 1'b0;
    ph = 2'h0;
    pend = 1'b0;
  end
  // idle lanes toggle so a stale byte never looks like live data
  always @(posedge clk) begin
    pend <= go;
    frame_start <= pend;
    line_in.valid <= go;
    line_in.slot <= go ? slot : ~line_in.slot;
    line_in.data <= go ? {data[7:1], abcd[~ph]} : ~line_in.data;
    if (!reset_n) begin
      ph <= 2'h0;
    end else if (pend) begin
      ph <= ph + 2'h1;
    end
  end
endmodule
`default_nettype wire

//--- verilog/cas_signaling_bandwidth_release.sv
// signaling transport and on-hook bandwidth release for one emulated circuit
//
// What this block does
// - signaling works only for structured circuits, never clear-channel ones
// - after reset signaling follows cfg.cas_en at once; reset clears the gathered ABCD bits and the multiframe phase
// - ingress gathers ABCD bits from slot data and sends them with payload
// - egress strips carried ABCD and rebuilds line bytes in the configured slot
// - with signaling each slot carries 7 user bits, one signaling bit per frame
// - hook detection needs signaling enabled and a one-slot circuit
// - in hook mode one slot per end; ingress and egress slots may differ
// - in hook mode ingress keeps classifying the circuit on-hook or off-hook
// - off-hook the ingress sends payload for every circuit byte
// - on-hook the ingress sends only periodic dummy cells
// - hook changes never drop the connection or its reservation
// - T1 offers 24 slots and E1 offers 31
`timescale 1ns/1ns
`default_nettype none
`include "cas_defs.svh"

module cas_signaling_bandwidth_release
  import cas_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire cfg_s cfg,
  input wire logic frame_start,
  input wire line_s line_in,
  input wire cell_s cell_in,
  output cell_s cell_out,
  output line_s line_out,
  output logic on_hook,
  output logic reserved
);

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  logic [4:0] slot_limit;
  logic [5:0] ing_end;
  logic [5:0] eg_end;
  logic circuit_ok;
  logic cas_active;
  logic hook_active;
  logic in_circuit;
  logic [4:0] ing_offset;

  assign slot_limit = cfg.e1 ? `CAS_E1_SLOTS : `CAS_T1_SLOTS;
  assign ing_end = {1'b0, cfg.ing_base} + {1'b0, cfg.count};
  assign eg_end = {1'b0, cfg.eg_base} + {1'b0, cfg.count};
  // a circuit that spills past the port's last slot is never carried
  assign circuit_ok = !cfg.structured ||
    (cfg.count != `CAS_ZERO_SLOT && ing_end <= {1'b0, slot_limit} &&
     eg_end <= {1'b0, slot_limit});
  assign cas_active = cfg.structured && cfg.cas_en && circuit_ok;
  assign hook_active = cas_active && cfg.hook_en && (cfg.count == `CAS_ONE_SLOT);
  assign ing_offset = cfg.structured ? (line_in.slot - cfg.ing_base) : line_in.slot;
  assign in_circuit = line_in.valid && circuit_ok && line_in.slot < slot_limit &&
    (!cfg.structured || ({1'b0, line_in.slot} >= {1'b0, cfg.ing_base} &&
     {1'b0, line_in.slot} < ing_end));

  // ----------------------------------------------------------------
  // multiframe phase, shared by both directions of the line
  // ----------------------------------------------------------------
  logic [1:0] phase_q;
  logic [1:0] phase_d;

  always_comb begin
    phase_d = phase_q;
    if (frame_start) begin
      phase_d = phase_q + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase_q <= `CAS_MF_FIRST;
    end else begin
      phase_q <= phase_d;
    end
  end

  // ----------------------------------------------------------------
  // per-slot ABCD gathering
  // ----------------------------------------------------------------
  logic [3:0] abcd_all [`CAS_MAX_SLOTS];

  genvar gi;
  generate
    for (gi = 0; gi < `CAS_MAX_SLOTS; gi++) begin : g_slot
      logic [3:0] sh_q;
      logic [3:0] sh_d;
      logic [3:0] abcd_q;
      logic [3:0] abcd_d;
      logic hit;

      // only the signaling bit of each frame is sampled; four frames make A..D
      assign hit = cas_active && line_in.valid && line_in.slot == 5'(gi);

      always_comb begin
        sh_d = sh_q;
        abcd_d = abcd_q;
        if (hit) begin
          sh_d = {sh_q[2:0], line_in.data[`CAS_SIG_BIT]};
          if (phase_q == `CAS_MF_LAST) begin
            abcd_d = {sh_q[2:0], line_in.data[`CAS_SIG_BIT]};
          end
        end
      end

      always_ff @(posedge clk) begin
        if (!reset_n) begin
          sh_q <= 4'h0;
          abcd_q <= 4'h0;
        end else begin
          sh_q <= sh_d;
          abcd_q <= abcd_d;
        end
      end

      assign abcd_all[gi] = abcd_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // hook classification
  // ----------------------------------------------------------------
  hook_e hook_q;
  hook_e hook_d;
  logic on_match;

  assign on_match = abcd_all[cfg.ing_base] == cfg.onhook_pat;

  always_comb begin
    hook_d = hook_q;
    unique case (hook_q)
      OFF_HOOK: begin
        if (hook_active && on_match) begin
          hook_d = ON_HOOK;
        end
      end
      ON_HOOK: begin
        if (!hook_active || !on_match) begin
          hook_d = OFF_HOOK;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hook_q <= OFF_HOOK;
    end else begin
      hook_q <= hook_d;
    end
  end

  // ----------------------------------------------------------------
  // ingress cell stream and dummy pacing
  // ----------------------------------------------------------------
  cell_s cell_q;
  cell_s cell_d;
  logic [15:0] dcnt_q;
  logic [15:0] dcnt_d;
  logic reserved_q;
  logic reserved_d;

  always_comb begin
    cell_d = '0;
    dcnt_d = `CAS_CNT_ZERO;
    // reservation follows configuration only, so hook state cannot drop it
    reserved_d = circuit_ok;
    if (hook_q == ON_HOOK) begin
      dcnt_d = dcnt_q;
      if (frame_start) begin
        if (dcnt_q >= cfg.dummy_int) begin
          dcnt_d = `CAS_CNT_ZERO;
          cell_d.valid = 1'b1;
          cell_d.dummy = 1'b1;
          cell_d.cas = 1'b1;
          cell_d.abcd = abcd_all[cfg.ing_base];
        end else begin
          dcnt_d = dcnt_q + `CAS_CNT_STEP;
        end
      end
    end else if (in_circuit) begin
      cell_d.valid = 1'b1;
      cell_d.offset = ing_offset;
      cell_d.payload = line_in.data;
      if (cas_active) begin
        // signaling bit slot is cleared: 7 user bits ride as payload
        cell_d.cas = 1'b1;
        cell_d.payload[`CAS_SIG_BIT] = 1'b0;
        cell_d.abcd = abcd_all[line_in.slot];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cell_q <= '0;
      dcnt_q <= `CAS_CNT_ZERO;
      reserved_q <= 1'b0;
    end else begin
      cell_q <= cell_d;
      dcnt_q <= dcnt_d;
      reserved_q <= reserved_d;
    end
  end

  // ----------------------------------------------------------------
  // egress rebuild
  // ----------------------------------------------------------------
  line_s lout_q;
  line_s lout_d;
  logic eg_take;

  assign eg_take = cell_in.valid && !cell_in.dummy && circuit_ok &&
    (cfg.structured ? cell_in.offset < cfg.count : cell_in.offset < slot_limit);

  always_comb begin
    lout_d = '0;
    if (eg_take) begin
      lout_d.valid = 1'b1;
      lout_d.slot = cfg.structured ? (cfg.eg_base + cell_in.offset) : cell_in.offset;
      lout_d.data = cell_in.payload;
      if (cas_active && cell_in.cas) begin
        lout_d.data[`CAS_SIG_BIT] = cell_in.abcd[`CAS_MF_LAST - phase_q];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lout_q <= '0;
    end else begin
      lout_q <= lout_d;
    end
  end

  assign cell_out = cell_q;
  assign line_out = lout_q;
  assign on_hook = (hook_q == ON_HOOK);
  assign reserved = reserved_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_offhook_byte;
    in_circuit && hook_q == OFF_HOOK;
  endsequence
  sequence s_payload_cell;
    cell_out.valid && !cell_out.dummy;
  endsequence
  sequence s_match_held;
    (hook_active && on_match) [*2];
  endsequence

  property p_cas_needs_enable;
    cell_out.valid && !cell_out.dummy |-> cell_out.cas == $past(cas_active);
  endproperty
  a_cas_needs_enable: assert property (p_cas_needs_enable)
    else $error("cell signaling flag disagrees with enable");

  property p_cas_structured;
    cell_out.cas |-> $past(cfg.structured);
  endproperty
  a_cas_structured: assert property (p_cas_structured)
    else $error("signaling on clear-channel circuit");

  property p_abcd_carried;
    s_offhook_byte ##0 cas_active |=> s_payload_cell ##0
      (cell_out.abcd == $past(abcd_all[line_in.slot]));
  endproperty
  a_abcd_carried: assert property (p_abcd_carried)
    else $error("ABCD nibble not carried with payload");

  property p_egress_slot;
    eg_take && cfg.structured |=> line_out.valid &&
      line_out.slot == $past(cfg.eg_base + cell_in.offset);
  endproperty
  a_egress_slot: assert property (p_egress_slot)
    else $error("egress byte in wrong slot");

  property p_user_bits;
    cell_out.cas && !cell_out.dummy |-> cell_out.payload[`CAS_SIG_BIT] == 1'b0;
  endproperty
  a_user_bits: assert property (p_user_bits)
    else $error("signaling bit left in user payload");

  property p_hook_gated;
    on_hook |-> $past(hook_active);
  endproperty
  a_hook_gated: assert property (p_hook_gated)
    else $error("on-hook without single-slot signaling");

  property p_classify;
    s_match_held |=> on_hook;
  endproperty
  a_classify: assert property (p_classify)
    else $error("on-hook pattern not classified");

  property p_offhook_sends;
    s_offhook_byte |=> s_payload_cell;
  endproperty
  a_offhook_sends: assert property (p_offhook_sends)
    else $error("off-hook byte not sent");

  property p_onhook_quiet;
    on_hook && $past(on_hook) |-> !(cell_out.valid && !cell_out.dummy);
  endproperty
  a_onhook_quiet: assert property (p_onhook_quiet)
    else $error("payload cell sent while on-hook");

  property p_reserved_kept;
    (hook_q != $past(hook_q)) && (cfg == $past(cfg)) && (cfg == $past(cfg, 2))
      |-> reserved == $past(reserved);
  endproperty
  a_reserved_kept: assert property (p_reserved_kept)
    else $error("reservation changed with hook state");

  property p_slot_limit;
    line_out.valid |-> line_out.slot < $past(slot_limit);
  endproperty
  a_slot_limit: assert property (p_slot_limit)
    else $error("egress slot beyond port limit");

endmodule
`default_nettype wire
